// *** lth_cfg.svh ***
// Constants of the low pin count target host port.
`ifndef LTH_CFG_SVH
`define LTH_CFG_SVH
// Start field that opens an I/O or DMA cycle.
`define LTH_START 4'h0
// Cycle type nibbles: bit 3 selects DMA, bit 1 the direction.
`define LTH_CT_IO_RD 4'h0
`define LTH_CT_IO_WR 4'h2
`define LTH_CT_DMA_RD 4'h8
`define LTH_CT_DMA_WR 4'ha
// Sync codes driven by the target.
`define LTH_SYNC_READY 4'h0
`define LTH_SYNC_SHORT 4'h5
`define LTH_SYNC_LONG 4'h6
// Turnaround value driven for one clock before release.
`define LTH_TAR 4'hf
// Least wait-state counts per cycle kind.
`define LTH_WAIT_IO_RD 3'h3
`define LTH_WAIT_IO_WR 3'h2
`define LTH_WAIT_DMA_RD 3'h3
`define LTH_WAIT_DMA_WR 3'h4
// DMA size field for a single byte.
`define LTH_SIZE_1B 2'h0
// Fixed keyboard block ports.
`define LTH_KBD_DATA 16'h0060
`define LTH_KBD_CMD 16'h0064
// Nibble count of an I/O address, minus one.
`define LTH_ADDR_LAST 3'h3
`endif

// *** lth_host_model.sv ***
// Host chipset model that runs cycles on the shared address/data lines.
`timescale 1ns/1ns
`default_nettype none
`include "lth_cfg.svh"
module lth_host_model (
  input wire logic lpc_clk_in,
  input wire logic [3:0] dev_lad_in,
  input wire logic dev_oe_in,
  output logic lframe_n_out,
  output logic [3:0] lad_wire_out
);
  logic [3:0] host_lad = 4'hf; // Nibble the host drives.
  logic host_oe = 1'b0; // High while the host drives.
  logic [3:0] last_wire = 4'h0; // Wire level at the last edge.
  logic clash = 1'b0; // Set if both parties ever drive together.
  initial lframe_n_out = 1'b1;
  // A released line shows the inverse of its last level.
  assign lad_wire_out = dev_oe_in ? dev_lad_in : (host_oe ? host_lad : ~last_wire);
  always @(posedge lpc_clk_in) last_wire <= lad_wire_out;
  // One bus clock; all host changes follow an edge.
  task automatic tick();
    @(posedge lpc_clk_in);
    if (dev_oe_in && host_oe) clash = 1'b1;
  endtask
  // Drive one nibble for one clock.
  task automatic put(input logic [3:0] v);
    host_lad <= v;
    host_oe <= 1'b1;
    tick();
  endtask
  // One cycle; ok: completed, tail_ok: lines handed back.
  task automatic run(input logic [3:0] start, input logic [3:0] ct, input logic [15:0] addr,
      input logic [3:0] chan, input logic [3:0] size, input logic [7:0] wdata, input int abort_at,
      output logic ok, output int waits, output logic [3:0] wcode, output logic [7:0] rdata,
      output logic tail_ok);
    int idle;
    ok = 1'b0;
    tail_ok = 1'b0;
    waits = 0;
    wcode = 4'h0;
    rdata = 8'h00;
    idle = 0;
    lframe_n_out <= 1'b0;
    put(start);
    lframe_n_out <= 1'b1;
    put(ct);
    if (ct[3]) begin
      put(chan);
      put(size);
    end else begin
      for (int i = 3; i >= 0; i--) put(addr[i*4+:4]);
    end
    if (ct == `LTH_CT_IO_WR || ct == `LTH_CT_DMA_RD) begin
      put(wdata[3:0]);
      put(wdata[7:4]);
    end
    put(`LTH_TAR);
    host_oe <= 1'b0;
    tick();
    // Sync phase: give up after four clocks with no drive.
    while (!ok && idle < 4 && waits < 40) begin
      tick();
      if (!dev_oe_in) idle++;
      else if (dev_lad_in === `LTH_SYNC_READY) ok = 1'b1;
      else begin
        waits++;
        wcode = dev_lad_in;
      end
      // Abort: frame low four clocks, lines driven high once the device let go.
      if (abort_at != 0 && waits == abort_at) begin
        lframe_n_out <= 1'b0;
        tick();
        tick();
        tail_ok = !dev_oe_in;
        host_lad <= `LTH_TAR;
        host_oe <= 1'b1;
        tick();
        tick();
        lframe_n_out <= 1'b1;
        host_oe <= 1'b0;
        tick();
        return;
      end
    end
    if (ok && (ct == `LTH_CT_IO_RD || ct == `LTH_CT_DMA_WR)) begin
      tick();
      rdata[3:0] = dev_lad_in;
      tick();
      rdata[7:4] = dev_lad_in;
    end
    if (ok) begin
      tick();
      tail_ok = dev_oe_in && dev_lad_in === `LTH_TAR;
      tick();
      tail_ok = tail_ok && !dev_oe_in;
    end
  endtask
endmodule
`default_nettype wire

// *** lth_pkg.sv ***
// Types of the low pin count target host port.
package lth_pkg;
  // Link state machine, one-hot.
  typedef enum logic [11:0] {
    LTH_IDLE = 12'h001,
    LTH_CTYP = 12'h002,
    LTH_ADDR = 12'h004,
    LTH_CHAN = 12'h008,
    LTH_SIZE = 12'h010,
    LTH_HDAT = 12'h020,
    LTH_TAR1 = 12'h040,
    LTH_TAR2 = 12'h080,
    LTH_SYNC = 12'h100,
    LTH_SRDY = 12'h200,
    LTH_DDAT = 12'h400,
    LTH_ETAR = 12'h800
  } lth_state_e;
endpackage

// *** lth_port.sv ***
// Target-side host port: cycle decoder, DMA request encoder and wake logic.
`timescale 1ns/1ns
`default_nettype none
`include "lth_cfg.svh"

// Behaviour
// - Decode only while core supply is good.
// - Wake, infrared and light outputs stay alive.
// - Supply loss disables infrared half-duplex timeout.
// - All reachable registers are eight bits.
// - Registers serviced by I/O or DMA.
// - Four single-byte cycle types supported.
// - Unsupported cycles ignored, lines left alone.
// - Frame low starts or aborts a cycle.
// - Bus reset resets all link logic.
// - Encoded DMA request line driven by device.
// - Open-drain active-low wake output asserted.
// - Power-down input readies interface for removal.
// - Nibbles exchanged over shared address/data lines.
// - Link logic runs on bus clock.
// - No clock-run signal exists.
// - Windows at configured bases, keyboard fixed.
// - Release lines clock after frame seen.
// - I/O waits: three read, two write, long.
// - In reset: ignore frame, float, request high.
// - Only start value zero is accepted.
module lth_port
  import lth_pkg::*;
#(
  parameter int NUM_WIN = 4,
  parameter int WIN_BITS = 3
) (
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic lpc_clk_in, // Free-running, no clock-run pin.
  input wire logic lpc_rstn_in,
  input wire logic lframe_n_in,
  input wire logic [3:0] lad_in,
  output logic [3:0] lad_out,
  output logic lad_oe_out,
  output logic ldrq_n_out,
  input wire logic lpcpd_n_in,
  input wire logic core_supply_good_in,
  input wire logic [NUM_WIN*16-1:0] win_base_in,
  input wire logic [NUM_WIN-1:0] win_en_in,
  input wire logic kbd_en_in,
  input wire logic [2:0] dma_chan_in,
  input wire logic dma_req_in,
  output logic acc_strobe_out,
  output logic [15:0] acc_addr_out,
  output logic [7:0] acc_wdata_out,
  output logic acc_write_out,
  output logic acc_dma_out,
  input wire logic resp_valid_in,
  input wire logic [7:0] resp_data_in,
  input wire logic wake_req_in,
  input wire logic wake_event_in_n,
  output logic wake_event_out_n,
  output logic wake_event_oe_out,
  output logic wake_line_low_out,
  input wire logic ir_tx_in,
  output logic ir_tx_out,
  input wire logic led_in,
  output logic led_out,
  input wire logic ir_timeout_en_in,
  output logic ir_hd_timeout_en_out
);

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  if (NUM_WIN < 1 || WIN_BITS < 1 || WIN_BITS > 15) begin : g_bad_param
    $error("lth_port: window parameters out of range.");
  end

  // Returns one for the two I/O cycle types.
  function automatic logic is_io(input logic [3:0] ct);
    is_io = (ct == `LTH_CT_IO_RD) || (ct == `LTH_CT_IO_WR);
  endfunction

  // Returns one for the two DMA cycle types.
  function automatic logic is_dma(input logic [3:0] ct);
    is_dma = (ct == `LTH_CT_DMA_RD) || (ct == `LTH_CT_DMA_WR);
  endfunction

  // ----------------------------------------
  // Link domain: synchronisers
  // ----------------------------------------
  logic pg_s1, pg_s2; // Supply good, two stages.
  logic pd_s1, pd_s2; // Power-down not asserted, two stages.
  logic dq_s1, dq_s2; // DMA request level, two stages.
  logic ack_s1, ack_s2; // Answer toggle, two stages.
  logic [2:0] ch_s1, ch_s2; // DMA channel, two stages.
  logic [NUM_WIN*16-1:0] wb_s1, wb_s2; // Window bases.
  logic [NUM_WIN-1:0] we_s1, we_s2; // Window enables.
  logic ke_s1, ke_s2; // Keyboard enable.
  logic ack_tgl; // Answer toggle toward the link.
  logic [7:0] resp_hold; // Answer byte, held for the link.

  // All slow inputs pass two flip-flops into the bus clock domain.
  always_ff @(posedge lpc_clk_in) begin
    if (!lpc_rstn_in) begin
      {pg_s1, pg_s2, pd_s1, pd_s2, dq_s1, dq_s2} <= 6'h00;
      {ch_s1, ch_s2, we_s1, we_s2, ke_s1, ke_s2} <= '0;
      {wb_s1, wb_s2} <= '0;
    end else begin
      {pg_s1, pg_s2} <= {core_supply_good_in, pg_s1};
      {pd_s1, pd_s2} <= {lpcpd_n_in, pd_s1};
      {dq_s1, dq_s2} <= {dma_req_in, dq_s1};
      {ch_s1, ch_s2} <= {dma_chan_in, ch_s1};
      {wb_s1, wb_s2} <= {win_base_in, wb_s1};
      {we_s1, we_s2, ke_s1, ke_s2} <= {win_en_in, we_s1, kbd_en_in, ke_s1};
    end
  end

  // The answer toggle is synchronised separately from the other levels.
  always_ff @(posedge lpc_clk_in) begin
    if (!lpc_rstn_in) begin
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
    end else begin
      ack_s1 <= ack_tgl;
      ack_s2 <= ack_s1;
    end
  end

  // ----------------------------------------
  // Link domain: cycle decoder
  // ----------------------------------------
  lth_state_e state, next_state; // Link state.
  logic [2:0] cnt, next_cnt; // Nibble and wait counter.
  logic [15:0] addr; // Captured I/O address.
  logic [7:0] wdata; // Byte sent by the host.
  logic [7:0] rdata; // Byte returned to the host.
  logic to_dev; // One when the host sends the data byte.
  logic cyc_dma; // One for a DMA cycle.
  logic req_tgl; // Request toggle toward the core side.
  logic [3:0] next_lad; // Next value on the shared lines.
  logic next_oe; // Next drive enable of the shared lines.
  logic dq_sent; // Request level last announced.
  logic [3:0] lsh; // Request bits still to send.
  logic [2:0] lcnt; // Request bits left.
  logic req_due; // Access waiting on the previous answer.

  wire ok = pg_s2 && pd_s2; // Decoding allowed.
  wire busy = req_tgl ^ ack_s2; // Core has not yet answered.
  wire [15:0] naddr = {addr[11:0], lad_in}; // Address with this nibble.
  wire last_nib = (cnt == `LTH_ADDR_LAST);
  wire [2:0] nw = cyc_dma ? (to_dev ? `LTH_WAIT_DMA_RD : `LTH_WAIT_DMA_WR)
                          : (to_dev ? `LTH_WAIT_IO_WR : `LTH_WAIT_IO_RD);
  wire [3:0] wait_code = cyc_dma ? `LTH_SYNC_SHORT : `LTH_SYNC_LONG;
  wire enter_tar = (next_state == LTH_TAR1) && (state != LTH_TAR1);
  wire [NUM_WIN-1:0] win_hit; // Per-window address match.
  wire kbd_hit = ke_s2 && (naddr == `LTH_KBD_DATA || naddr == `LTH_KBD_CMD);
  wire addr_hit = kbd_hit || (|win_hit);

  // Each window compares the address above its span with its base.
  for (genvar i = 0; i < NUM_WIN; i++) begin : g_win
    assign win_hit[i] = we_s2[i] && (naddr[15:WIN_BITS] == wb_s2[i*16+WIN_BITS +: 16-WIN_BITS]);
  end

  // Next state: frame low always restarts the decoder.
  always_comb begin
    next_state = state;
    next_cnt = cnt + 3'h1;
    if (!lframe_n_in) begin
      next_cnt = 3'h0;
      next_state = (ok && lad_in == `LTH_START) ? LTH_CTYP : LTH_IDLE;
    end else begin
      case (state)
        LTH_IDLE: begin
          next_state = LTH_IDLE;
        end
        LTH_CTYP: begin
          next_cnt = 3'h0;
          if (is_io(lad_in)) begin
            next_state = LTH_ADDR;
          end else if (is_dma(lad_in)) begin
            next_state = LTH_CHAN;
          end else begin
            next_state = LTH_IDLE;
          end
        end
        LTH_ADDR: begin
          if (last_nib) begin
            next_state = !addr_hit ? LTH_IDLE : (to_dev ? LTH_HDAT : LTH_TAR1);
            next_cnt = 3'h0;
          end
        end
        LTH_CHAN: begin
          next_state = (lad_in[2:0] == ch_s2) ? LTH_SIZE : LTH_IDLE;
        end
        LTH_SIZE: begin
          next_cnt = 3'h0;
          if (lad_in[1:0] != `LTH_SIZE_1B) begin
            next_state = LTH_IDLE;
          end else begin
            next_state = to_dev ? LTH_HDAT : LTH_TAR1;
          end
        end
        LTH_HDAT: begin
          if (cnt[0]) begin
            next_state = LTH_TAR1;
          end
        end
        LTH_TAR1: begin
          next_state = LTH_TAR2;
        end
        LTH_TAR2: begin
          next_cnt = 3'h0;
          next_state = LTH_SYNC;
        end
        LTH_SYNC: begin
          // Wait codes last at least nw clocks and until the core answers.
          if (cnt >= nw - 3'h1 && !busy && !req_due) begin
            next_state = LTH_SRDY;
          end
          if (cnt >= nw) begin
            next_cnt = cnt;
          end
        end
        LTH_SRDY: begin
          next_cnt = 3'h0;
          next_state = to_dev ? LTH_ETAR : LTH_DDAT;
        end
        LTH_DDAT: begin
          if (cnt[0]) begin
            next_state = LTH_ETAR;
          end
        end
        LTH_ETAR: begin
          next_state = LTH_IDLE;
        end
        default: begin
          next_state = LTH_IDLE;
        end
      endcase
    end
  end

  // Drive only in sync, data and our turnaround phases.
  always_comb begin
    next_oe = 1'b1;
    case (next_state)
      LTH_SYNC: next_lad = wait_code;
      LTH_SRDY: next_lad = `LTH_SYNC_READY;
      LTH_DDAT: next_lad = (state == LTH_DDAT) ? rdata[7:4] : resp_hold[3:0];
      LTH_ETAR: next_lad = `LTH_TAR;
      default: begin
        next_lad = 4'h0;
        next_oe = 1'b0;
      end
    endcase
  end

  // State, counter and bus drive registers, cleared by bus reset.
  always_ff @(posedge lpc_clk_in) begin
    if (!lpc_rstn_in) begin
      state <= LTH_IDLE;
      cnt <= 3'h0;
      lad_out <= 4'h0;
      lad_oe_out <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      lad_out <= next_lad;
      lad_oe_out <= next_oe;
    end
  end

  // Captured fields of the current cycle.
  always_ff @(posedge lpc_clk_in) begin
    if (!lpc_rstn_in) begin
      {addr, wdata, rdata, to_dev, cyc_dma, req_tgl, req_due} <= '0;
    end else begin
      if (state == LTH_CTYP) begin
        to_dev <= is_io(lad_in) ? lad_in[1] : !lad_in[1];
        cyc_dma <= is_dma(lad_in);
      end
      if (state == LTH_ADDR) begin
        addr <= naddr;
      end
      if (state == LTH_HDAT) begin
        wdata <= cnt[0] ? {lad_in, wdata[3:0]} : {4'h0, lad_in};
      end
      if (state == LTH_SRDY) begin
        rdata <= resp_hold; // Stable: answer toggle already seen.
      end
      if (enter_tar) begin
        req_due <= 1'b1;
      end else if (req_due && !busy) begin
        req_tgl <= ~req_tgl;
        req_due <= 1'b0;
      end
    end
  end

  // Encoded request: start bit, channel, active bit, then high.
  always_ff @(posedge lpc_clk_in) begin
    if (!lpc_rstn_in) begin
      ldrq_n_out <= 1'b1;
      lsh <= 4'h0;
      lcnt <= 3'h0;
      dq_sent <= 1'b0;
    end else if (!ok) begin
      ldrq_n_out <= 1'b1;
      lcnt <= 3'h0;
    end else if (lcnt != 3'h0) begin
      ldrq_n_out <= lsh[3];
      lsh <= {lsh[2:0], 1'b1};
      lcnt <= lcnt - 3'h1;
    end else if (dq_s2 != dq_sent) begin
      ldrq_n_out <= 1'b0;
      lsh <= {ch_s2, dq_s2};
      lcnt <= 3'h4;
      dq_sent <= dq_s2;
    end else begin
      ldrq_n_out <= 1'b1;
    end
  end

  // ----------------------------------------
  // Core domain: access handshake and side outputs
  // ----------------------------------------
  logic rq_s1, rq_s2, rq_s3; // Request toggle, synchronised plus edge stage.
  logic pend; // An access awaits its answer.
  logic pgy_s1, pgy_s2; // Supply good in this domain.
  logic wk_s1, wk_s2; // Wake line level.

  wire rq_edge = rq_s2 ^ rq_s3; // New access from the link.

  // Hands each access to the core and returns its answer.
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      {rq_s1, rq_s2, rq_s3, ack_tgl, pend, acc_strobe_out} <= 6'h00;
      {acc_addr_out, acc_wdata_out, acc_write_out, acc_dma_out, resp_hold} <= '0;
    end else begin
      {rq_s1, rq_s2, rq_s3} <= {req_tgl, rq_s1, rq_s2};
      acc_strobe_out <= rq_edge;
      if (rq_edge) begin
        acc_addr_out <= addr;
        acc_wdata_out <= wdata;
        acc_write_out <= to_dev;
        acc_dma_out <= cyc_dma;
        pend <= 1'b1;
      end else if (pend && resp_valid_in) begin
        resp_hold <= resp_data_in;
        ack_tgl <= ~ack_tgl;
        pend <= 1'b0;
      end
    end
  end

  // Trickle-side outputs run whatever the supply state, save the half-duplex timeout enable, which needs supply good.
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      {pgy_s1, pgy_s2, wk_s1, wk_s2} <= 4'h0;
      {wake_event_oe_out, wake_line_low_out, ir_tx_out, led_out} <= 4'h0;
      {wake_event_out_n, ir_hd_timeout_en_out} <= 2'h0;
    end else begin
      {pgy_s1, pgy_s2} <= {core_supply_good_in, pgy_s1};
      {wk_s1, wk_s2} <= {wake_event_in_n, wk_s1};
      wake_event_out_n <= 1'b0;
      wake_event_oe_out <= wake_req_in;
      wake_line_low_out <= !wk_s2;
      ir_tx_out <= ir_tx_in;
      led_out <= led_in;
      ir_hd_timeout_en_out <= pgy_s2 && ir_timeout_en_in;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_frame_release;
    @(posedge lpc_clk_in) disable iff (!lpc_rstn_in) !lframe_n_in |=> !lad_oe_out;
  endproperty
  a_frame_release: assert property (p_frame_release) else $error("Lines driven after frame.");

  property p_reset_quiet;
    @(posedge lpc_clk_in) disable iff (1'b0) !lpc_rstn_in |=> ldrq_n_out && !lad_oe_out;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("Bus not quiet in reset.");

  property p_supply_gate;
    @(posedge lpc_clk_in) disable iff (!lpc_rstn_in) state == LTH_CTYP |-> $past(pg_s2) && $past(pd_s2);
  endproperty
  a_supply_gate: assert property (p_supply_gate) else $error("Cycle decoded without supply.");

  property p_io_rd_waits;
    @(posedge lpc_clk_in) disable iff (!lpc_rstn_in)
      state == LTH_SRDY && !cyc_dma && !to_dev |-> $past(state == LTH_SYNC, 3) && $past(state == LTH_SYNC, 1);
  endproperty
  a_io_rd_waits: assert property (p_io_rd_waits) else $error("Too few read waits.");

  property p_io_wr_waits;
    @(posedge lpc_clk_in) disable iff (!lpc_rstn_in)
      state == LTH_SRDY && !cyc_dma && to_dev |-> $past(state == LTH_SYNC, 2);
  endproperty
  a_io_wr_waits: assert property (p_io_wr_waits) else $error("Too few write waits.");

  property p_long_code;
    @(posedge lpc_clk_in) disable iff (!lpc_rstn_in)
      state == LTH_SYNC && !cyc_dma |-> lad_oe_out && lad_out == `LTH_SYNC_LONG;
  endproperty
  a_long_code: assert property (p_long_code) else $error("Wrong I/O wait code.");

  property p_bad_type;
    @(posedge lpc_clk_in) disable iff (!lpc_rstn_in)
      state == LTH_CTYP && lframe_n_in && !is_io(lad_in) && !is_dma(lad_in) |=> state == LTH_IDLE ##1 !lad_oe_out;
  endproperty
  a_bad_type: assert property (p_bad_type) else $error("Unsupported cycle not ignored.");

  property p_owned_only;
    @(posedge lpc_clk_in) disable iff (!lpc_rstn_in)
      lad_oe_out |-> state inside {LTH_SYNC, LTH_SRDY, LTH_DDAT, LTH_ETAR};
  endproperty
  a_owned_only: assert property (p_owned_only) else $error("Lines driven outside owned phase.");

  property p_powerdown;
    @(posedge lpc_clk_in) disable iff (!lpc_rstn_in) !pd_s2 |=> ldrq_n_out;
  endproperty
  a_powerdown: assert property (p_powerdown) else $error("Request sent in power-down.");

  property p_ir_timeout;
    @(posedge clock_in) disable iff (!rstn_in) !pgy_s2 |=> !ir_hd_timeout_en_out;
  endproperty
  a_ir_timeout: assert property (p_ir_timeout) else $error("Timeout on without supply.");

  property p_wake;
    @(posedge clock_in) disable iff (!rstn_in) wake_req_in |=> wake_event_oe_out && !wake_event_out_n;
  endproperty
  a_wake: assert property (p_wake) else $error("Wake output not pulled low.");

endmodule
`default_nettype wire

// *** test_lpc_target_host_port.sv ***
// Self-checking testbench for the low pin count target host port.
`timescale 1ns/1ns
`default_nettype none
`include "lth_cfg.svh"
module test_lpc_target_host_port;
  logic clock_in = 1'b0, rstn_in = 1'b0, lpc_clk_in = 1'b0, lpc_rstn_in = 1'b0;
  logic lpcpd_n = 1'b1, supply = 1'b1, kbd_en = 1'b1, dma_req = 1'b0, resp_valid = 1'b0;
  logic wake_req = 1'b0, ext_pull = 1'b0, ir_tx = 1'b0, led = 1'b0, ir_to_en = 1'b1;
  logic [7:0] resp_data = 8'h00;
  logic [2:0] dma_chan = 3'h2;
  logic [3:0] win_en = 4'h7; // Window at 0x0300 is off.
  logic [63:0] win_base = 64'h0300_02f8_03f8_0378;
  wire lframe_n, lad_oe, ldrq_n, acc_strobe, acc_write, acc_dma, wake_out_n, wake_oe, wake_low;
  wire ir_tx_o, led_o, ir_to_o, wake_in_n;
  wire [3:0] lad_wire, lad_out;
  wire [15:0] acc_addr;
  wire [7:0] acc_wdata;
  int fail_count = 0, cmp_count = 0, strobes = 0, resp_delay = 1, resp_cnt = 0;
  logic pending = 1'b0, ok, tail;
  int waits;
  logic [3:0] wcode;
  logic [7:0] rdata;
  // Open-drain wake line with a pull-up; either party may pull it low.
  assign wake_in_n = !((wake_oe && !wake_out_n) || ext_pull);
  always #10 clock_in = ~clock_in;
  // Bus clock, 48 ns, offset in phase from the core clock.
  initial #7 forever #24 lpc_clk_in = ~lpc_clk_in;
  lth_port #(.NUM_WIN(4), .WIN_BITS(3)) DUT (
    .clock_in(clock_in), .rstn_in(rstn_in), .lpc_clk_in(lpc_clk_in), .lpc_rstn_in(lpc_rstn_in),
    .lframe_n_in(lframe_n), .lad_in(lad_wire), .lad_out(lad_out), .lad_oe_out(lad_oe),
    .ldrq_n_out(ldrq_n), .lpcpd_n_in(lpcpd_n), .core_supply_good_in(supply),
    .win_base_in(win_base), .win_en_in(win_en), .kbd_en_in(kbd_en), .dma_chan_in(dma_chan),
    .dma_req_in(dma_req), .acc_strobe_out(acc_strobe), .acc_addr_out(acc_addr),
    .acc_wdata_out(acc_wdata), .acc_write_out(acc_write), .acc_dma_out(acc_dma),
    .resp_valid_in(resp_valid), .resp_data_in(resp_data), .wake_req_in(wake_req),
    .wake_event_in_n(wake_in_n), .wake_event_out_n(wake_out_n), .wake_event_oe_out(wake_oe),
    .wake_line_low_out(wake_low), .ir_tx_in(ir_tx), .ir_tx_out(ir_tx_o), .led_in(led),
    .led_out(led_o), .ir_timeout_en_in(ir_to_en), .ir_hd_timeout_en_out(ir_to_o));
  lth_host_model host (.lpc_clk_in(lpc_clk_in), .dev_lad_in(lad_out), .dev_oe_in(lad_oe),
    .lframe_n_out(lframe_n), .lad_wire_out(lad_wire));
  // Core side: counts accesses, raises resp_valid resp_delay + 1 clocks after each strobe.
  always @(posedge clock_in) begin
    resp_valid <= 1'b0;
    if (acc_strobe === 1'b1) begin
      strobes++;
      pending = 1'b1;
      resp_cnt = resp_delay;
    end else if (pending && resp_cnt == 0) begin
      resp_valid <= 1'b1;
      pending = 1'b0;
    end else if (pending) begin
      resp_cnt--;
    end
  end
  // One comparison; a mismatch is reported at once.
  task automatic chk(input logic good, input string msg);
    cmp_count++;
    if (good !== 1'b1) begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask
  // I/O read; ab aborts after that many waits.
  task automatic io_rd(input logic [15:0] a, input int ab);
    host.run(`LTH_START, `LTH_CT_IO_RD, a, 4'h0, 4'h0, 8'h00, ab, ok, waits, wcode, rdata, tail);
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic results();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Each cycle kind, the two I/O kinds twice; keyboard ports and a window's last byte.
  task automatic t_cycles();
    logic [3:0] ct [6] = '{`LTH_CT_IO_RD, `LTH_CT_IO_WR, `LTH_CT_IO_RD, `LTH_CT_IO_WR,
      `LTH_CT_DMA_RD, `LTH_CT_DMA_WR};
    logic [15:0] ad [6] = '{16'h037f, 16'h03f8, `LTH_KBD_DATA, `LTH_KBD_CMD, 16'h0000, 16'h0000};
    int min_w [6] = '{3, 2, 3, 2, 3, 4};
    int s;
    logic tx;
    for (int i = 0; i < 6; i++) begin
      s = strobes;
      tx = ct[i][1] ^ ct[i][3];
      @(posedge clock_in) resp_data <= 8'h3c + 8'(i * 17);
      host.run(`LTH_START, ct[i], ad[i], {1'b0, dma_chan}, 4'h0, 8'hc3 - 8'(i), 0, ok, waits, wcode, rdata, tail);
      chk(ok && tail, "cycle not completed");
      chk(waits >= min_w[i] && waits <= min_w[i] + 4, "wait count");
      chk(wcode === (ct[i][3] ? `LTH_SYNC_SHORT : `LTH_SYNC_LONG), "wait code");
      chk(strobes == s + 1 && acc_write === tx && acc_dma === ct[i][3], "core access kind");
      if (!ct[i][3]) chk(acc_addr === ad[i], "core address");
      if (tx) chk(acc_wdata === 8'hc3 - 8'(i), "write byte");
      else chk(rdata === 8'h3c + 8'(i * 17), "read byte");
    end
    $display("Test cycles done");
  endtask
  // Cycles to ignore: bad start, type, address, channel, size.
  task automatic t_refuse();
    logic [3:0] st [6] = '{4'h1, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0};
    logic [3:0] ct [6] = '{`LTH_CT_IO_RD, 4'h4, `LTH_CT_IO_RD, `LTH_CT_IO_WR, `LTH_CT_DMA_RD, `LTH_CT_DMA_WR};
    logic [15:0] ad [6] = '{`LTH_KBD_DATA, `LTH_KBD_DATA, 16'h0380, 16'h0300, 16'h0000, 16'h0000};
    int s;
    for (int i = 0; i < 6; i++) begin
      s = strobes;
      host.run(st[i], ct[i], ad[i], (i == 4) ? 4'h5 : {1'b0, dma_chan}, {3'h0, i == 5}, 8'h5a, 0,
        ok, waits, wcode, rdata, tail);
      chk(!ok && strobes == s, "foreign cycle answered");
    end
    @(posedge clock_in) kbd_en <= 1'b0;
    io_rd(`LTH_KBD_CMD, 0);
    chk(!ok, "keyboard port answered while off");
    @(posedge clock_in) kbd_en <= 1'b1;
    chk(host.clash === 1'b0, "both parties drove the lines");
    $display("Test refuse done");
  endtask
  // Slow core, abort in mid-sync, then a clean cycle.
  task automatic t_abort();
    resp_delay = 30;
    io_rd(`LTH_KBD_DATA, 0);
    chk(ok && waits > 3 && wcode === `LTH_SYNC_LONG, "slow core waits");
    io_rd(`LTH_KBD_DATA, 2);
    chk(tail, "lines driven after abort");
    resp_delay = 1;
    host.run(`LTH_START, `LTH_CT_IO_WR, `LTH_KBD_CMD, 4'h0, 4'h0, 8'h11, 0, ok, waits, wcode, rdata, tail);
    chk(ok && tail && waits >= 2, "cycle after abort");
    $display("Test abort done");
  endtask
  // A request change sends start, channel MSB first, level, idle high.
  task automatic ldrq_msg(input logic act);
    logic [4:0] bits;
    int n;
    n = 0;
    @(posedge clock_in) dma_req <= act;
    while (ldrq_n !== 1'b0 && n < 40) begin
      @(posedge lpc_clk_in);
      n++;
    end
    for (int i = 4; i >= 0; i--) begin
      @(posedge lpc_clk_in);
      bits[i] = ldrq_n;
    end
    chk(n < 40 && bits === {dma_chan, act, 1'b1}, "request message");
    $display("Test request line done");
  endtask
  // Supply loss and power-down stop decoding; trickle outputs carry on.
  task automatic t_power();
    @(posedge clock_in) begin
      supply <= 1'b0;
      ir_tx <= 1'b1;
      led <= 1'b1;
      wake_req <= 1'b1;
    end
    repeat (10) @(posedge clock_in);
    chk(ir_to_o === 1'b0, "half-duplex timeout left on");
    chk(ir_tx_o === 1'b1 && led_o === 1'b1, "trickle outputs stopped");
    chk(wake_oe === 1'b1 && wake_out_n === 1'b0 && wake_low === 1'b1, "wake not pulled");
    io_rd(`LTH_KBD_DATA, 0);
    chk(!ok && ldrq_n === 1'b1, "decoded without supply");
    @(posedge clock_in) begin
      supply <= 1'b1;
      ir_tx <= 1'b0;
      led <= 1'b0;
      wake_req <= 1'b0;
      ext_pull <= 1'b1;
      lpcpd_n <= 1'b0;
    end
    repeat (10) @(posedge clock_in);
    chk(ir_to_o === 1'b1 && ir_tx_o === 1'b0 && led_o === 1'b0, "outputs stuck");
    chk(wake_oe === 1'b0 && wake_low === 1'b1, "outside wake pull");
    io_rd(`LTH_KBD_DATA, 0);
    chk(!ok && ldrq_n === 1'b1, "decoded in power-down");
    @(posedge clock_in) begin
      lpcpd_n <= 1'b1;
      ext_pull <= 1'b0;
    end
    repeat (10) @(posedge clock_in);
    $display("Test power done");
  endtask
  // Mid-cycle bus reset releases the lines; frames ignored until release.
  task automatic t_reset();
    resp_delay = 40;
    fork
      io_rd(`LTH_KBD_DATA, 0);
      begin
        repeat (11) @(posedge lpc_clk_in);
        lpc_rstn_in <= 1'b0;
      end
    join
    chk(!ok && lad_oe === 1'b0 && ldrq_n === 1'b1, "active in bus reset");
    resp_delay = 1;
    io_rd(`LTH_KBD_DATA, 0);
    chk(!ok && ldrq_n === 1'b1, "frame seen in bus reset");
    repeat (50) @(posedge clock_in);
    @(posedge lpc_clk_in) lpc_rstn_in <= 1'b1;
    repeat (4) @(posedge lpc_clk_in);
    io_rd(`LTH_KBD_DATA, 0);
    chk(ok && tail, "no decode after bus reset");
    $display("Test reset done");
  endtask
  // Main sequence.
  initial begin
    repeat (2) @(posedge clock_in);
    rstn_in <= 1'b1;
    repeat (3) @(posedge lpc_clk_in);
    lpc_rstn_in <= 1'b1;
    repeat (4) @(posedge lpc_clk_in);
    t_cycles();
    t_refuse();
    t_abort();
    ldrq_msg(1'b1);
    ldrq_msg(1'b0);
    t_power();
    t_reset();
    results();
  end
  // Watchdog against a hang.
  initial begin
    #400000;
    fail_count++;
    $display("CHECK FAILED at %0t: run did not finish", $time);
    results();
  end
endmodule
`default_nettype wire
